// ===== core/dsicmd_pkg.sv
// Shared constants and types for the clear / OTP / format command handler
package dsicmd_pkg;

    // ==========================================================
    // Command codes and addresses
    localparam logic [3:0] DSICMD_CMD_CLEAR = 4'h7;
    localparam logic [3:0] DSICMD_CMD_NVM = 4'h9;
    localparam logic [3:0] DSICMD_CMD_FMT = 4'ha;
    localparam logic [3:0] DSICMD_GLOBAL_ADDR = 4'h0;

    // ==========================================================
    // Response patterns
    localparam logic [3:0] DSICMD_NVM_OFF_ZERO = 4'h0;
    localparam logic [3:0] DSICMD_NVM_OFF_ONES = 4'hf;
    localparam logic [1:0] DSICMD_NVM_ON_ONES = 2'h3;
    localparam logic [3:0] DSICMD_FMT_PATTERN = 4'h6;

    // ==========================================================
    // Format registers
    localparam int DSICMD_FMT_REGS = 8;
    localparam logic [2:0] DSICMD_FMT_CRC_LEN = 3'h4;
    localparam logic [2:0] DSICMD_FMT_SW_LEN = 3'h5;
    localparam logic [2:0] DSICMD_FMT_RSVD = 3'h6;
    localparam logic [2:0] DSICMD_FMT_SEL = 3'h7;
    localparam logic [3:0] DSICMD_CRC_LEN_MAX = 4'h8;
    localparam logic [3:0] DSICMD_SW_LEN_MIN = 4'h8;
    localparam logic [3:0] DSICMD_SEL_CUSTOM = 4'hf;
    localparam logic [3:0] DSICMD_SEL_STD = 4'h0;
    // Index 7 down to 0; also the standard format values
    localparam logic [7:0][3:0] DSICMD_FMT_RESET = 32'h00840a11;

    // ==========================================================
    // OTP layout: five 16-bit programming groups
    localparam int DSICMD_OTP_GROUPS = 5;
    localparam int DSICMD_OTP_GW = 16;
    localparam logic [2:0] DSICMD_GRP_CFG = 3'h0;
    localparam logic [3:0] DSICMD_REG_CFG1 = 4'h6;
    localparam logic [3:0] DSICMD_REG_CFG2 = 4'h7;
    localparam logic [3:0] DSICMD_REG_USER_FIRST = 4'h8;
    localparam logic [3:0] DSICMD_REG_USER_LAST = 4'hf;
    localparam logic [3:0] DSICMD_POS_CFG1_LO = 4'h0;
    localparam logic [3:0] DSICMD_POS_CFG1_HI = 4'h4;
    localparam logic [3:0] DSICMD_POS_ADDR = 4'h8;
    localparam logic [3:0] DSICMD_POS_DEVICE_DISABLE_BIT = 4'hc;
    localparam logic [3:0] DSICMD_POS_GLOBAL_ADDR_ENABLE_BIT = 4'hd;
    localparam logic [3:0] DSICMD_POS_PAR = 4'he;
    localparam logic [3:0] DSICMD_POS_LOCK = 4'hf;
    localparam logic [3:0] DSICMD_POS_UPPER = 4'h4;
    localparam logic [3:0] DSICMD_POS_ODD = 4'h8;
    localparam logic [1:0] DSICMD_BANK_0 = 2'h0;
    localparam logic [1:0] DSICMD_BANK_1 = 2'h1;
    localparam logic [1:0] DSICMD_BANK_2 = 2'h2;
    localparam logic [1:0] DSICMD_BANK_3 = 2'h3;
    localparam logic [3:0] DSICMD_MASK_NIB = 4'hf;
    localparam logic [3:0] DSICMD_MASK_BIT = 4'h1;

    // ==========================================================
    // Types
    typedef struct packed {
        logic is_long;
        logic crc_ok;
        logic [3:0] addr;
        logic [3:0] cmd;
        logic [7:0] data;
    } dsicmd_frame_t;

    typedef struct packed {
        logic [3:0] reg_addr;
        logic [3:0] nibble;
    } dsicmd_nvm_data_t;

    typedef struct packed {
        logic wr;
        logic [2:0] sel;
        logic [3:0] nibble;
    } dsicmd_fmt_data_t;

    typedef struct packed {
        logic [7:0] crc_poly;
        logic [7:0] seed;
        logic [3:0] crc_len;
        logic [3:0] sw_len;
    } dsicmd_fmt_set_t;

    typedef struct packed {
        logic ok;
        logic [2:0] grp;
        logic [3:0] lsb;
        logic [3:0] mask;
    } dsicmd_field_t;

endpackage

// ===== core/dsicmd_otp.sv
// OTP field store: 80 bits in five 16-bit programming groups
`timescale 1ns/1ps

module dsicmd_otp
    import dsicmd_pkg::*;
#(
    parameter int GROUPS = DSICMD_OTP_GROUPS
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic acc_i,
    input wire logic prog_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [1:0] bank_i,
    input wire logic [3:0] wdata_i,
    input wire logic [3:0] dev_addr_i,
    output logic field_ok_o,
    output logic [3:0] field_data_o,
    output logic device_disable_bit_o,
    output logic global_addr_enable_bit_o
);

    typedef struct packed {
        logic [GROUPS-1:0][DSICMD_OTP_GW-1:0] grp;
    } dsicmd_otp_state_t;

    dsicmd_otp_state_t st;
    dsicmd_otp_state_t next_st;
    dsicmd_field_t fld;
    logic [DSICMD_OTP_GW-1:0] cur;
    logic [DSICMD_OTP_GW-1:0] wmask;
    logic [DSICMD_OTP_GW-1:0] wval;

    // ==========================================================
    // Field map
    function automatic dsicmd_field_t field_map(input logic [3:0] ra, input logic [1:0] bk);
        dsicmd_field_t f;
        f = '0;
        if (ra == DSICMD_REG_CFG1) begin
            f.grp = DSICMD_GRP_CFG;
            f.mask = DSICMD_MASK_NIB;
            f.ok = (bk == DSICMD_BANK_1) || (bk == DSICMD_BANK_2);
            f.lsb = (bk == DSICMD_BANK_2) ? DSICMD_POS_CFG1_HI : DSICMD_POS_CFG1_LO;
        end else if (ra == DSICMD_REG_CFG2) begin
            f.grp = DSICMD_GRP_CFG;
            f.ok = 1'b1;
            case (bk)
                DSICMD_BANK_0: begin
                    f.lsb = DSICMD_POS_LOCK;
                    f.mask = DSICMD_MASK_BIT;
                end
                DSICMD_BANK_1: begin
                    f.lsb = DSICMD_POS_ADDR;
                    f.mask = DSICMD_MASK_NIB;
                end
                DSICMD_BANK_2: begin
                    f.lsb = DSICMD_POS_GLOBAL_ADDR_ENABLE_BIT;
                    f.mask = DSICMD_MASK_BIT;
                end
                default: begin
                    f.lsb = DSICMD_POS_PAR;
                    f.mask = DSICMD_MASK_BIT;
                end
            endcase
        end else if (ra >= DSICMD_REG_USER_FIRST) begin
            f.grp = 3'(((ra - DSICMD_REG_USER_FIRST) >> 1) + 4'h1);
            f.mask = DSICMD_MASK_NIB;
            f.ok = (bk == DSICMD_BANK_1) || (bk == DSICMD_BANK_2);
            f.lsb = (ra[0] ? DSICMD_POS_ODD : 4'h0) | ((bk == DSICMD_BANK_2) ? DSICMD_POS_UPPER : 4'h0);
            if (ra == DSICMD_REG_USER_LAST && bk == DSICMD_BANK_3) begin
                f.ok = 1'b1;
                f.grp = DSICMD_GRP_CFG;
                f.lsb = DSICMD_POS_DEVICE_DISABLE_BIT;
                f.mask = DSICMD_MASK_BIT;
            end
        end
        return f;
    endfunction

    // ==========================================================
    // Programming: bits only ever set, whole group at once
    always_comb begin
        fld = field_map(reg_addr_i, bank_i);
        next_st = st;
        cur = st.grp[fld.grp];
        wmask = DSICMD_OTP_GW'({12'h000, fld.mask} << fld.lsb);
        wval = DSICMD_OTP_GW'({12'h000, wdata_i} << fld.lsb) & wmask;
        if (fld.grp == DSICMD_GRP_CFG) begin
            wval = wval | DSICMD_OTP_GW'({12'h000, dev_addr_i} << DSICMD_POS_ADDR);
        end
        if (acc_i && prog_i && fld.ok) begin
            next_st.grp[fld.grp] = cur | wval;
        end
        field_ok_o = fld.ok;
        field_data_o = 4'((next_st.grp[fld.grp] >> fld.lsb)) & fld.mask;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign device_disable_bit_o = st.grp[DSICMD_GRP_CFG][DSICMD_POS_DEVICE_DISABLE_BIT];
    assign global_addr_enable_bit_o = st.grp[DSICMD_GRP_CFG][DSICMD_POS_GLOBAL_ADDR_ENABLE_BIT];

endmodule

// ===== core/dsicmd_core.sv
// Command handler for clear, OTP read/write and format control frames
`timescale 1ns/1ps

module dsicmd_core
    import dsicmd_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic frame_valid_i,
    input wire dsicmd_frame_t frame_i,
    input wire logic [3:0] dev_addr_i,
    input wire logic nvm_enable_flag_i,
    input wire logic [1:0] bank_sel_i,
    output logic resp_valid_o,
    output logic [15:0] resp_word_o,
    output logic clear_reset_o,
    output logic bus_switch_open_o,
    output logic fmt_custom_o,
    output dsicmd_fmt_set_t fmt_active_o,
    output logic device_disable_bit_o,
    output logic global_addr_enable_bit_o
);

    typedef struct packed {
        logic [DSICMD_FMT_REGS-1:0][3:0] fmt;
        logic resp_valid;
        logic [15:0] resp_word;
        logic clear_pulse;
        logic switch_open;
    } dsicmd_state_t;

    dsicmd_state_t st;
    dsicmd_state_t next_st;
    dsicmd_nvm_data_t nvm_d;
    dsicmd_fmt_data_t fmt_d;
    logic hit;
    logic addr_own;
    logic addr_glb;
    logic clear_go;
    logic nvm_go;
    logic fmt_go;
    logic otp_ok;
    logic [3:0] otp_nib;
    logic [DSICMD_FMT_REGS-1:0][3:0] fmt_eff;

    // ==========================================================
    // Format register write with per-register guards
    function automatic logic [DSICMD_FMT_REGS-1:0][3:0] fmt_write(
        input logic [DSICMD_FMT_REGS-1:0][3:0] regs,
        input logic [2:0] sel,
        input logic [3:0] val
    );
        logic [DSICMD_FMT_REGS-1:0][3:0] r;
        r = regs;
        case (sel)
            DSICMD_FMT_CRC_LEN: begin
                if (val <= DSICMD_CRC_LEN_MAX) begin
                    r[sel] = val;
                end
            end
            DSICMD_FMT_SW_LEN: begin
                if (val >= DSICMD_SW_LEN_MIN) begin
                    r[sel] = val;
                end
            end
            DSICMD_FMT_RSVD: begin
                r[sel] = regs[sel];
            end
            DSICMD_FMT_SEL: begin
                if (val == DSICMD_SEL_CUSTOM) begin
                    r[sel] = DSICMD_SEL_CUSTOM;
                end
            end
            default: begin
                r[sel] = val;
            end
        endcase
        return r;
    endfunction

    // ==========================================================
    // Frame decode
    always_comb begin
        nvm_d = dsicmd_nvm_data_t'(frame_i.data);
        fmt_d = dsicmd_fmt_data_t'(frame_i.data);
        hit = frame_valid_i && frame_i.crc_ok;
        addr_own = (frame_i.addr == dev_addr_i);
        addr_glb = (frame_i.addr == DSICMD_GLOBAL_ADDR);
        // Any frame length, data bits unused
        clear_go = hit && (frame_i.cmd == DSICMD_CMD_CLEAR) && (addr_own || addr_glb);
        // Global address takes precedence over an own address of zero
        nvm_go = hit && frame_i.is_long && (frame_i.cmd == DSICMD_CMD_NVM) && addr_own && !addr_glb;
        fmt_go = hit && frame_i.is_long && (frame_i.cmd == DSICMD_CMD_FMT) && (addr_own || addr_glb);
    end

    dsicmd_otp u_otp (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .acc_i(nvm_go),
        .prog_i(nvm_enable_flag_i),
        .reg_addr_i(nvm_d.reg_addr),
        .bank_i(bank_sel_i),
        .wdata_i(nvm_d.nibble),
        .dev_addr_i(dev_addr_i),
        .field_ok_o(otp_ok),
        .field_data_o(otp_nib),
        .device_disable_bit_o(device_disable_bit_o),
        .global_addr_enable_bit_o(global_addr_enable_bit_o)
    );

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.resp_valid = 1'b0;
        next_st.clear_pulse = 1'b0;
        if (clear_go) begin
            // Format registers back to defaults, bus switch opened, never answered
            next_st.fmt = DSICMD_FMT_RESET;
            next_st.switch_open = 1'b1;
            next_st.clear_pulse = 1'b1;
        end else if (nvm_go) begin
            next_st.resp_valid = 1'b1;
            if (nvm_enable_flag_i) begin
                next_st.resp_word = {frame_i.addr, nvm_d.reg_addr, DSICMD_NVM_ON_ONES, bank_sel_i,
                                     otp_ok ? otp_nib : 4'h0};
            end else begin
                next_st.resp_word = {frame_i.addr, DSICMD_NVM_OFF_ZERO, DSICMD_NVM_OFF_ONES,
                                     frame_i.addr};
            end
        end else if (fmt_go) begin
            if (fmt_d.wr) begin
                next_st.fmt = fmt_write(st.fmt, fmt_d.sel, fmt_d.nibble);
            end
            if (!addr_glb) begin
                next_st.resp_valid = 1'b1;
                next_st.resp_word = {frame_i.addr, DSICMD_FMT_PATTERN, fmt_d.wr, fmt_d.sel,
                                     next_st.fmt[fmt_d.sel]};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st <= '{fmt: DSICMD_FMT_RESET, resp_valid: 1'b0, resp_word: 16'h0000,
                    clear_pulse: 1'b0, switch_open: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    always_comb begin
        fmt_eff = fmt_custom_o ? st.fmt : DSICMD_FMT_RESET;
        fmt_active_o = '{crc_poly: {fmt_eff[1], fmt_eff[0]}, seed: {fmt_eff[3], fmt_eff[2]},
                         crc_len: fmt_eff[DSICMD_FMT_CRC_LEN], sw_len: fmt_eff[DSICMD_FMT_SW_LEN]};
    end

    assign fmt_custom_o = (st.fmt[DSICMD_FMT_SEL] == DSICMD_SEL_CUSTOM);
    assign resp_valid_o = st.resp_valid;
    assign resp_word_o = st.resp_word;
    assign clear_reset_o = st.clear_pulse;
    assign bus_switch_open_o = st.switch_open;

    // ==========================================================
    // Assertions
    a_clear_opens_switch: assert property (@(posedge clk_i) disable iff (!resetn_i)
        clear_go |=> clear_reset_o && bus_switch_open_o && !fmt_custom_o)
        else $error("Clear did not reset and open switch");

    a_clear_short_ok: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (hit && !frame_i.is_long && frame_i.cmd == DSICMD_CMD_CLEAR && addr_glb) |=> clear_reset_o)
        else $error("Short clear frame not accepted");

    a_clear_no_resp: assert property (@(posedge clk_i) disable iff (!resetn_i)
        clear_reset_o |-> !resp_valid_o)
        else $error("Response sent to clear");

    a_nvm_global_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (hit && frame_i.cmd == DSICMD_CMD_NVM && addr_glb) |=> !resp_valid_o && $stable(device_disable_bit_o))
        else $error("Global OTP command acted");

    a_nvm_short_silent: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (frame_valid_i && !frame_i.is_long && frame_i.cmd == DSICMD_CMD_NVM) |=> !resp_valid_o)
        else $error("Response to short OTP command");

    a_nvm_off_word: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (nvm_go && !nvm_enable_flag_i) |=>
            resp_valid_o && resp_word_o == {$past(frame_i.addr), 8'h0f, $past(frame_i.addr)})
        else $error("Wrong OTP reply with NVM disabled");

    a_nvm_on_word: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (nvm_go && nvm_enable_flag_i) |=> resp_valid_o
            && resp_word_o[15:4] == {$past(frame_i.addr), $past(frame_i.data[7:4]), 2'b11, $past(bank_sel_i)})
        else $error("Wrong OTP reply with NVM enabled");

    a_fmt_short_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (frame_valid_i && !frame_i.is_long && frame_i.cmd == DSICMD_CMD_FMT) |=> $stable(st.fmt) && !resp_valid_o)
        else $error("Short format frame had an effect");

    a_fmt_global_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (fmt_go && addr_glb) |=> !resp_valid_o)
        else $error("Response to global format command");

    a_fmt_reply_word: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (fmt_go && !addr_glb) |=> resp_valid_o
            && resp_word_o[15:4] == {$past(frame_i.addr), 4'h6, $past(frame_i.data[7:4])})
        else $error("Wrong format reply");

    a_fmt_read_only: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (fmt_go && !fmt_d.wr) |=> $stable(st.fmt))
        else $error("Format read changed a register");

    a_crc_len_guard: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (fmt_go && fmt_d.wr && fmt_d.sel == 3'h4 && fmt_d.nibble > 4'h8) |=> $stable(st.fmt[4]))
        else $error("CRC length accepted above eight");

    a_swlen_guard: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (fmt_go && fmt_d.wr && fmt_d.sel == 3'h5 && fmt_d.nibble < 4'h8) |=> $stable(st.fmt[5]))
        else $error("Short-word length accepted below eight");

    a_sel_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (fmt_custom_o && !clear_go) |=> fmt_custom_o)
        else $error("Format selection left all ones");

    a_crc_bad_drop: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (frame_valid_i && !frame_i.crc_ok) |=> !resp_valid_o && !clear_reset_o && $stable(st.fmt))
        else $error("Bad CRC frame had an effect");

    a_clear_other_addr: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (hit && frame_i.cmd == DSICMD_CMD_CLEAR && !addr_own && !addr_glb)
            |=> !clear_reset_o && $stable(bus_switch_open_o))
        else $error("Clear to a foreign address acted");

    a_clear_fmt_default: assert property (@(posedge clk_i) disable iff (!resetn_i)
        clear_go |=> st.fmt == DSICMD_FMT_RESET)
        else $error("Clear left format registers changed");

    a_switch_held: assert property (@(posedge clk_i) disable iff (!resetn_i)
        bus_switch_open_o |=> bus_switch_open_o)
        else $error("Bus switch closed without reset");

    a_nvm_other_addr: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (hit && frame_i.cmd == DSICMD_CMD_NVM && !addr_own) |=> !resp_valid_o)
        else $error("OTP command to another address answered");

    a_nvm_no_prog: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (nvm_go && !nvm_enable_flag_i) |=> $stable(device_disable_bit_o) && $stable(global_addr_enable_bit_o))
        else $error("OTP programmed with NVM disabled");

    a_fmt_write_lands: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (fmt_go && fmt_d.wr && fmt_d.sel < DSICMD_FMT_CRC_LEN) |=> st.fmt[$past(fmt_d.sel)] == $past(fmt_d.nibble))
        else $error("Format write did not land");

    a_std_formats: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !fmt_custom_o |-> fmt_active_o.crc_len == DSICMD_FMT_RESET[DSICMD_FMT_CRC_LEN]
            && fmt_active_o.sw_len == DSICMD_FMT_RESET[DSICMD_FMT_SW_LEN])
        else $error("Custom format used before selection");

    a_sel_clear_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!fmt_custom_o && fmt_go && fmt_d.wr && fmt_d.sel == DSICMD_FMT_SEL && fmt_d.nibble != DSICMD_SEL_CUSTOM)
            |=> !fmt_custom_o)
        else $error("Partial selection write took effect");

    a_crc_len_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
        st.fmt[DSICMD_FMT_CRC_LEN] <= DSICMD_CRC_LEN_MAX)
        else $error("CRC length register above eight");

    a_swlen_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
        st.fmt[DSICMD_FMT_SW_LEN] >= DSICMD_SW_LEN_MIN)
        else $error("Short-word length register below eight");

    a_resp_needs_frame: assert property (@(posedge clk_i) disable iff (!resetn_i)
        resp_valid_o |-> $past(frame_valid_i && frame_i.crc_ok))
        else $error("Response without a good frame");

    a_clear_needs_frame: assert property (@(posedge clk_i) disable iff (!resetn_i)
        clear_reset_o |-> $past(hit))
        else $error("Clear pulse without a good frame");

    c_clear_seen: cover property (@(posedge clk_i) disable iff (!resetn_i) clear_go ##1 clear_reset_o);
    c_nvm_prog: cover property (@(posedge clk_i) disable iff (!resetn_i) nvm_go && nvm_enable_flag_i);
    c_fmt_custom: cover property (@(posedge clk_i) disable iff (!resetn_i) !fmt_custom_o ##1 fmt_custom_o);
    c_fmt_read: cover property (@(posedge clk_i) disable iff (!resetn_i) fmt_go && !fmt_d.wr && !addr_glb);
    c_fmt_global: cover property (@(posedge clk_i) disable iff (!resetn_i) fmt_go && addr_glb && fmt_d.wr);

endmodule

// ===== bench/dsicmd_master_model.sv
// Bus master model that presents received command frames to the handler
`timescale 1ns/1ps

module dsicmd_master_model
    import dsicmd_pkg::*;
(
    input wire logic clk_i,
    output logic frame_valid_o,
    output dsicmd_frame_t frame_o
);
    initial begin
        frame_valid_o = 1'h0;
        frame_o = '0;
    end

    // ==========================================================
    // One frame, valid for exactly one rising edge
    task automatic send(input dsicmd_frame_t f);
        @(negedge clk_i);
        frame_valid_o = 1'h1;
        frame_o = f;
        @(negedge clk_i);
        frame_valid_o = 1'h0;
        // Stale lines show the inverse, never the last frame
        frame_o = ~f;
    endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking testbench for the clear, OTP and format command handler
`timescale 1ns/1ps

module tb_top
    import dsicmd_pkg::*;
;
    typedef struct packed {
        dsicmd_frame_t f;
        logic nv;
        logic [1:0] bk;
        logic ev;
        logic ec;
        logic [15:0] w;
    } dsicmd_row_t;

    localparam logic [3:0] cf = DSICMD_CMD_FMT;
    localparam logic [3:0] cn = DSICMD_CMD_NVM;
    localparam logic [3:0] cc = DSICMD_CMD_CLEAR;

    logic clk_i = 1'h0;
    logic resetn_i = 1'h0;
    logic frame_valid;
    dsicmd_frame_t frame;
    logic [3:0] dev_addr = 4'h5;
    logic nvm = 1'h0;
    logic [1:0] bank = 2'h0;
    logic resp_valid;
    logic [15:0] resp_word;
    logic clear_reset;
    logic bus_open;
    logic custom;
    dsicmd_fmt_set_t active;
    logic device_disable_bit;
    logic global_addr_enable_bit;
    int fails = 0;
    int checked = 0;
    dsicmd_row_t rows[$];

    always #12.5 clk_i = ~clk_i;

    dsicmd_master_model u_dsicmd_master_model (.clk_i(clk_i), .frame_valid_o(frame_valid), .frame_o(frame));

    dsicmd_core u_dsicmd_core (
        .clk_i(clk_i), .resetn_i(resetn_i), .frame_valid_i(frame_valid), .frame_i(frame),
        .dev_addr_i(dev_addr), .nvm_enable_flag_i(nvm), .bank_sel_i(bank),
        .resp_valid_o(resp_valid), .resp_word_o(resp_word), .clear_reset_o(clear_reset),
        .bus_switch_open_o(bus_open), .fmt_custom_o(custom), .fmt_active_o(active),
        .device_disable_bit_o(device_disable_bit), .global_addr_enable_bit_o(global_addr_enable_bit)
    );

    // ==========================================================
    // Helpers
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic add(input logic l, c, input logic [3:0] a, cmd, input logic [7:0] d,
                       input logic nv, input logic [1:0] bk, input logic ev, ec, input logic [15:0] w);
        rows.push_back('{'{l, c, a, cmd, d}, nv, bk, ev, ec, w});
    endtask

    task automatic frm(input logic l, c, input logic [3:0] a, cmd);
        u_dsicmd_master_model.send('{l, c, a, cmd, 8'ha5});
    endtask

    task automatic tally_and_finish;
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        @(negedge clk_i) resetn_i = 1'h1;
        check(resp_valid, 24'h0);
        check(resp_word, 24'h0);
        check(bus_open, 24'h0);
        check(active, 24'h110a48);
        add(1'h1, 1'h1, 4'h5, cf, 8'hc3, 1'h0, 2'h0, 1'h1, 1'h0, 16'h56c3);
        add(1'h1, 1'h1, 4'h5, cf, 8'h43, 1'h0, 2'h0, 1'h1, 1'h0, 16'h5643);
        add(1'h1, 1'h1, 4'h5, cf, 8'hc9, 1'h0, 2'h0, 1'h1, 1'h0, 16'h56c3);
        add(1'h1, 1'h1, 4'h5, cf, 8'hd7, 1'h0, 2'h0, 1'h1, 1'h0, 16'h56d8);
        add(1'h1, 1'h1, 4'h5, cf, 8'hfe, 1'h0, 2'h0, 1'h1, 1'h0, 16'h56f0);
        add(1'h0, 1'h1, 4'h5, cf, 8'h85, 1'h0, 2'h0, 1'h0, 1'h0, 16'h0);
        add(1'h1, 1'h1, 4'h5, cf, 8'h00, 1'h0, 2'h0, 1'h1, 1'h0, 16'h5601);
        add(1'h1, 1'h1, 4'h0, cf, 8'h85, 1'h0, 2'h0, 1'h0, 1'h0, 16'h0);
        add(1'h1, 1'h1, 4'h5, cf, 8'h00, 1'h0, 2'h0, 1'h1, 1'h0, 16'h5605);
        add(1'h1, 1'h1, 4'h5, cf, 8'hff, 1'h0, 2'h0, 1'h1, 1'h1, 16'h56ff);
        add(1'h1, 1'h1, 4'h5, cf, 8'hf0, 1'h0, 2'h0, 1'h1, 1'h1, 16'h56ff);
        add(1'h1, 1'h0, 4'h5, cf, 8'h89, 1'h0, 2'h0, 1'h0, 1'h1, 16'h0);
        add(1'h1, 1'h1, 4'h5, cf, 8'h00, 1'h0, 2'h0, 1'h1, 1'h1, 16'h5605);
        add(1'h1, 1'h1, 4'h5, cn, 8'h8a, 1'h0, 2'h1, 1'h1, 1'h1, 16'h50f5);
        add(1'h0, 1'h1, 4'h5, cn, 8'h8a, 1'h1, 2'h1, 1'h0, 1'h1, 16'h0);
        add(1'h1, 1'h1, 4'h0, cn, 8'h8a, 1'h1, 2'h1, 1'h0, 1'h1, 16'h0);
        add(1'h1, 1'h1, 4'h5, cn, 8'h80, 1'h1, 2'h1, 1'h1, 1'h1, 16'h58d0);
        add(1'h1, 1'h1, 4'h5, cn, 8'h8a, 1'h1, 2'h1, 1'h1, 1'h1, 16'h58da);
        add(1'h1, 1'h1, 4'h5, cn, 8'h83, 1'h1, 2'h2, 1'h1, 1'h1, 16'h58e3);
        add(1'h1, 1'h1, 4'h5, cn, 8'h80, 1'h1, 2'h1, 1'h1, 1'h1, 16'h58da);
        add(1'h1, 1'h1, 4'h5, cn, 8'hf1, 1'h1, 2'h3, 1'h1, 1'h1, 16'h5ff1);
        add(1'h1, 1'h1, 4'h5, cn, 8'h71, 1'h1, 2'h2, 1'h1, 1'h1, 16'h57e1);
        add(1'h1, 1'h1, 4'h5, cn, 8'h70, 1'h1, 2'h1, 1'h1, 1'h1, 16'h57d5);
        add(1'h1, 1'h1, 4'h5, cn, 8'h8f, 1'h1, 2'h0, 1'h1, 1'h1, 16'h58c0);
        add(1'h1, 1'h1, 4'h5, cn, 8'h71, 1'h1, 2'h0, 1'h1, 1'h1, 16'h57c1);
        foreach (rows[i]) begin
            nvm = rows[i].nv;
            bank = rows[i].bk;
            u_dsicmd_master_model.send(rows[i].f);
            check(resp_valid, rows[i].ev);
            if (rows[i].ev) check(resp_word, rows[i].w);
            check(custom, rows[i].ec);
        end
        // ==========================================================
        // Awkward cases
        check(device_disable_bit, 24'h1);
        check(global_addr_enable_bit, 24'h1);
        check(active, 24'h150a38);
        frm(1'h1, 1'h1, 4'h3, cc);
        check({clear_reset, bus_open}, 24'h0);
        frm(1'h1, 1'h0, 4'h5, cc);
        check({clear_reset, bus_open}, 24'h0);
        frm(1'h1, 1'h1, 4'h5, cc);
        check({clear_reset, bus_open, resp_valid}, 24'h6);
        check(active, 24'h110a48);
        frm(1'h0, 1'h1, 4'h0, cc);
        check({clear_reset, resp_valid}, 24'h2);
        @(negedge clk_i) resetn_i = 1'h0;
        repeat (2) @(negedge clk_i);
        resetn_i = 1'h1;
        check({bus_open, device_disable_bit, global_addr_enable_bit}, 24'h0);
        tally_and_finish();
    end
endmodule
